// File: rtl/dsss_transmit_serializer.v
// Purpose: Transmit serializer with direct-sequence spreading
// Assumes: Register port and mode inputs on the same clock as clk
// Notes: Read data are registered, one cycle after reg_rd
`include "dsss_tx_regs.vh"

// Overview of operation
// - Done flag sets when a byte finishes, after one bit sent; status read clears.
// - Empty flag shows whenever no byte is pending for the serializer.
// - Flags set and readable regardless of any interrupt enable.
// - Transmit status reads zero unless transmit enabled and receive disabled.
// - Writes to the status register are ignored.
// - Data byte goes out bit 0 first, ascending to bit 7.
// - Valid mask one sends data bit; zero below the highest one sends preamble that bit time.
// - Sending never stops in transmit mode; an empty shifter sends preamble bits.
// - Code used as 64 chips per bit, or as 32-chip halves: low, high, or both alternating.
// - Chips go out upward through the code: bits 0 to 63, or 0 to 31 / 32 to 63 in 32-chip modes.
// - Underflow sets when a bit is needed but none loaded, after one sent.
module dsss_transmit_serializer #(
  parameter [15:0] CHIP_CYCLES = `CHIP_CYCLES_DEF
) (
  // Clock, reset, enable
  input wire clk,
  input wire resetn,
  input wire ce,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Mode control
  input wire tx_enable,
  input wire rx_enable,
  input wire [1:0] code_mode,
  // Chip stream
  output reg chip_out,
  output reg chip_strobe,
  output reg tx_active
);

  ////////////////////////////////////////////////////////////////////////
  // State
  reg [7:0] data_r;
  reg [7:0] valid_r;
  reg pend_r;
  reg [7:0] sh_data_r;
  reg [7:0] sh_mask_r;
  reg byte_busy_r;
  reg sent_any_r;
  reg done_r;
  reg under_r;
  reg over_r;
  reg cur_bit_r;
  reg half_r;
  reg [5:0] chip_cnt_r;
  reg [15:0] div_r;
  reg [15:0] div_nxt;
  reg [7:0] rd_value;
  wire [63:0] code;

  wire tx_mode = tx_enable & ~rx_enable;
  wire wr_data = reg_wr && reg_addr == `ADDR_TX_DATA;
  wire wr_valid = reg_wr && reg_addr == `ADDR_TX_VALID;
  wire wr_code = reg_wr && reg_addr >= `ADDR_CODE_FIRST &&
                 reg_addr <= `ADDR_CODE_LAST;
  wire [7:0] code_off = reg_addr - `ADDR_CODE_FIRST;
  wire rd_status = reg_rd && reg_addr == `ADDR_TX_IRQ_STATUS;

  spreading_code_store u_code (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .wr_en(wr_code),
    .wr_idx(code_off[2:0]),
    .wr_data(reg_wdata),
    .code(code)
  );

  ////////////////////////////////////////////////////////////////////////
  // Chip timing
  wire tick = tx_active && div_r == CHIP_CYCLES - 16'h0001;
  wire full = code_mode == `MODE_FULL64;
  wire last_chip = chip_cnt_r == (full ? `LAST_CHIP64 : `LAST_CHIP32);
  wire bit_start = tx_mode & (~tx_active | (tick & last_chip));
  reg [5:0] chip_idx;

  always @* begin
    div_nxt = div_r + 16'h0001;
    if (!tx_mode || !tx_active || tick) begin
      div_nxt = 16'h0000;
    end
  end

  always @* begin
    case (code_mode)
      `MODE_FULL64: chip_idx = chip_cnt_r;
      `MODE_LOW32: chip_idx = {1'b0, chip_cnt_r[4:0]};
      `MODE_HIGH32: chip_idx = {1'b1, chip_cnt_r[4:0]};
      `MODE_BOTH32: chip_idx = {half_r, chip_cnt_r[4:0]};
      default: chip_idx = chip_cnt_r;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit source selection at each bit boundary
  reg load;
  reg [7:0] src_data;
  reg [7:0] src_mask;

  always @* begin
    load = 1'b0;
    src_data = sh_data_r;
    src_mask = sh_mask_r;
    if (sh_mask_r == 8'h00 && pend_r) begin
      load = 1'b1;
      src_data = data_r;
      src_mask = valid_r;
    end
  end

  wire have_bit = src_mask != 8'h00;
  wire next_bit = src_mask[0] ? src_data[0] : `PREAMBLE_BIT;

  ////////////////////////////////////////////////////////////////////////
  // Host registers and serializer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_r <= `TX_DATA_RESET;
      valid_r <= `TX_VALID_RESET;
      pend_r <= 1'b0;
      sh_data_r <= 8'h00;
      sh_mask_r <= 8'h00;
      byte_busy_r <= 1'b0;
      sent_any_r <= 1'b0;
      done_r <= 1'b0;
      under_r <= 1'b0;
      over_r <= 1'b0;
      cur_bit_r <= `PREAMBLE_BIT;
      half_r <= 1'b0;
      chip_cnt_r <= 6'h00;
      div_r <= 16'h0000;
      tx_active <= 1'b0;
      chip_out <= 1'b0;
      chip_strobe <= 1'b0;
      reg_rdata <= 8'h00;
    end else if (ce) begin
      // Status read clears first; a same-cycle event below wins
      if (rd_status) begin
        done_r <= 1'b0;
        under_r <= 1'b0;
        over_r <= 1'b0;
      end
      if (wr_valid) begin
        valid_r <= reg_wdata;
      end
      if (wr_data) begin
        data_r <= reg_wdata;
        if (pend_r && !(bit_start && load)) begin
          over_r <= 1'b1;
        end
      end
      div_r <= div_nxt;
      if (!tx_mode) begin
        // Leaving transmit mode drops the byte in flight
        tx_active <= 1'b0;
        chip_cnt_r <= 6'h00;
        sh_mask_r <= 8'h00;
        byte_busy_r <= 1'b0;
        sent_any_r <= 1'b0;
        half_r <= 1'b0;
      end else if (bit_start) begin
        tx_active <= 1'b1;
        chip_cnt_r <= 6'h00;
        half_r <= tx_active ? ~half_r : 1'b0;
        cur_bit_r <= have_bit ? next_bit : `PREAMBLE_BIT;
        sh_data_r <= {1'b0, src_data[7:1]};
        sh_mask_r <= {1'b0, src_mask[7:1]};
        if (sh_mask_r == 8'h00 && byte_busy_r) begin
          done_r <= 1'b1;
        end
        if (have_bit) begin
          sent_any_r <= 1'b1;
        end else if (sent_any_r) begin
          under_r <= 1'b1;
        end
        byte_busy_r <= have_bit;
      end else if (tick) begin
        chip_cnt_r <= chip_cnt_r + 6'h01;
      end
      // Pending byte is taken by the shifter; a new write re-arms it
      if (wr_data) begin
        pend_r <= 1'b1;
      end else if (tx_mode && bit_start && load) begin
        pend_r <= 1'b0;
      end
      // Bit 1 sends the code, bit 0 its inverse
      chip_strobe <= tx_active && tx_mode && div_r == 16'h0000;
      if (tx_active && tx_mode && div_r == 16'h0000) begin
        chip_out <= code[chip_idx] ^ ~cur_bit_r;
      end
      if (reg_rd) begin
        reg_rdata <= rd_value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data; status writes simply fall through the decode
  wire [7:0] status_raw = {4'h0, under_r, over_r, done_r, ~pend_r};

  always @* begin
    rd_value = 8'h00;
    if (reg_addr == `ADDR_TX_IRQ_STATUS) begin
      rd_value = tx_mode ? status_raw : 8'h00;
    end else if (reg_addr == `ADDR_TX_DATA) begin
      rd_value = data_r;
    end else if (reg_addr == `ADDR_TX_VALID) begin
      rd_value = valid_r;
    end else if (wr_code || (reg_addr >= `ADDR_CODE_FIRST &&
                             reg_addr <= `ADDR_CODE_LAST)) begin
      rd_value = code[{code_off[2:0], 3'h0} +: 8];
    end
  end

endmodule // dsss_transmit_serializer

// File: rtl/dsss_tx_regs.vh
// Purpose: Shared constants of the spread-spectrum transmit serializer
// Assumes: Byte-wide register port, one register per address
// Notes: Definitions only
`ifndef DSSS_TX_REGS_VH
`define DSSS_TX_REGS_VH

////////////////////////////////////////////////////////////////////////
// Register addresses
`define ADDR_TX_IRQ_STATUS 8'h0E
`define ADDR_TX_DATA 8'h0F
`define ADDR_TX_VALID 8'h10
`define ADDR_CODE_FIRST 8'h11
`define ADDR_CODE_LAST 8'h18

////////////////////////////////////////////////////////////////////////
// Status field positions
`define STAT_EMPTY 0
`define STAT_DONE 1
`define STAT_OVERFLOW 2
`define STAT_UNDERFLOW 3

////////////////////////////////////////////////////////////////////////
// Reset values
`define TX_DATA_RESET 8'h00
`define TX_VALID_RESET 8'h00
`define CODE_RESET 64'h0000000000000000

////////////////////////////////////////////////////////////////////////
// Spreading modes
`define MODE_FULL64 2'h0
`define MODE_LOW32 2'h1
`define MODE_HIGH32 2'h2
`define MODE_BOTH32 2'h3

////////////////////////////////////////////////////////////////////////
// Timing and symbols
`define CHIP_CYCLES_DEF 16'h0014
`define PREAMBLE_BIT 1'b0
`define LAST_CHIP64 6'h3F
`define LAST_CHIP32 6'h1F

`endif

// File: rtl/spreading_code_store.v
// Purpose: Eight-byte spreading code storage
// Assumes: One byte written per cycle
// Notes: Whole code is presented from flip-flops
`include "dsss_tx_regs.vh"

module spreading_code_store (
  // Clock and reset
  input wire clk,
  input wire resetn,
  input wire ce,
  // Byte write
  input wire wr_en,
  input wire [2:0] wr_idx,
  input wire [7:0] wr_data,
  // Whole code
  output wire [63:0] code
);

  reg [63:0] code_r;
  localparam [63:0] CODE_INIT = `CODE_RESET;

  ////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_byte
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          code_r[8*i+7:8*i] <= CODE_INIT[8*i+7:8*i];
        end else if (ce && wr_en && wr_idx == i) begin
          code_r[8*i+7:8*i] <= wr_data;
        end
      end
    end
  endgenerate

  assign code = code_r;

endmodule // spreading_code_store

// File: verification/air_receiver.sv
// Purpose: Remote receiver model despreading the chips
// Assumes: Error-free air link, one chip per strobe
// Notes: Any chip error gives a zero bit, no threshold
module air_receiver (
  input wire clk,
  input wire resetn,
  input wire active,
  input wire strobe,
  input wire chip,
  input wire [63:0] code,
  input wire [1:0] mode,
  output reg [7:0] bits_r
);
  timeunit 1ns / 1ps;
  reg [5:0] idx_r;
  reg miss_r;
  reg alt_r;
  wire hi = mode == 2'h2 || (mode == 2'h3 && alt_r);
  wire ref_chip = code[{hi, 5'h00} + idx_r];
  wire miss_nxt = miss_r | (chip != ref_chip);
  wire last = idx_r == (mode == 2'h0 ? 6'h3F : 6'h1F);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bits_r <= 8'h00;
      idx_r <= 6'h00;
      miss_r <= 1'h0;
      alt_r <= 1'h0;
    end else if (!active) begin
      idx_r <= 6'h00;
      miss_r <= 1'h0;
      alt_r <= 1'h0;
    end else if (strobe) begin
      idx_r <= last ? 6'h00 : idx_r + 6'h01;
      miss_r <= last ? 1'h0 : miss_nxt;
      alt_r <= alt_r ^ last;
      if (last)
        bits_r <= {~miss_nxt, bits_r[7:1]};
    end
  end
endmodule // air_receiver

// File: verification/dsss_transmit_serializer_tb_top.sv
// Purpose: Register-level test of the transmit serializer
// Assumes: Chip period cut to two cycles
// Notes: Receiver model despreads the chips
`include "dsss_tx_regs.vh"
module dsss_transmit_serializer_tb_top;
  timeunit 1ns / 1ps;
  localparam [63:0] CODE = 64'h3C5A96E10F87D24B;
  reg clk, resetn, ce, reg_wr, reg_rd, tx_enable, rx_enable;
  reg [7:0] reg_addr, reg_wdata, s, mk, d;
  reg [1:0] code_mode, m;
  reg [3:0] n;
  wire [7:0] reg_rdata, bits;
  wire chip_out, chip_strobe, tx_active;
  int errors = 0, cmp_count = 0;
  reg [21:0] tab [0:5] = '{{2'h0, 8'hFF, 8'hA5, 4'h8},
    {2'h1, 8'hFF, 8'h3C, 4'h8}, {2'h2, 8'hFF, 8'hC3, 4'h8},
    {2'h3, 8'hFF, 8'h96, 4'h8}, {2'h0, 8'h0F, 8'h3C, 4'h4},
    {2'h0, 8'h5A, 8'hFF, 4'h7}};
  dsss_transmit_serializer #(.CHIP_CYCLES(16'h0002)) dut (.clk(clk),
    .resetn(resetn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_enable(tx_enable), .rx_enable(rx_enable), .code_mode(code_mode),
    .chip_out(chip_out), .chip_strobe(chip_strobe), .tx_active(tx_active));
  air_receiver rx (.clk(clk), .resetn(resetn), .active(tx_active),
    .strobe(chip_strobe), .chip(chip_out), .code(CODE), .mode(code_mode),
    .bits_r(bits));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task wr(input [7:0] a, input [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task rd(input [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 s = reg_rdata;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rdc(input [7:0] a, input [7:0] exp);
    rd(a);
    chk(s, exp);
  endtask
  task set_mode(input t, input r, input [1:0] cm);
    @(posedge clk);
    tx_enable <= t;
    rx_enable <= r;
    code_mode <= cm;
  endtask
  task complete_run;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    complete_run;
  end
  initial begin
    {resetn, ce, reg_wr, reg_rd, tx_enable, rx_enable} = 6'h10;
    {reg_addr, reg_wdata, code_mode} = 18'h00000;
    repeat (8) @(posedge clk);
    resetn <= 1'h1;
    rdc(`ADDR_TX_DATA, 8'h00);
    rdc(`ADDR_TX_VALID, 8'h00);
    rdc(`ADDR_TX_IRQ_STATUS, 8'h00);
    for (int i = 0; i < 8; i++)
      wr(`ADDR_CODE_FIRST + 8'(i), CODE[8*i +: 8]);
    for (int i = 0; i < 8; i++)
      rdc(`ADDR_CODE_FIRST + 8'(i), CODE[8*i +: 8]);
    rdc(8'h20, 8'h00);
    @(posedge clk) ce <= 1'h0;
    wr(`ADDR_TX_VALID, 8'hA5);
    @(posedge clk) ce <= 1'h1;
    rdc(`ADDR_TX_VALID, 8'h00);
    wr(`ADDR_TX_DATA, 8'h00);
    wr(`ADDR_TX_DATA, 8'h00);
    set_mode(1'h1, 1'h0, 2'h0);
    rdc(`ADDR_TX_IRQ_STATUS, 8'h05);
    wr(`ADDR_TX_IRQ_STATUS, 8'hFF);
    rdc(`ADDR_TX_IRQ_STATUS, 8'h01);
    set_mode(1'h1, 1'h1, 2'h0);
    rdc(`ADDR_TX_IRQ_STATUS, 8'h00);
    set_mode(1'h0, 1'h0, 2'h0);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      {m, mk, d, n} = tab[i];
      wr(`ADDR_TX_VALID, mk);
      wr(`ADDR_TX_DATA, d);
      set_mode(1'h1, 1'h0, m);
      s = 8'h00;
      for (int k = 0; k < 1000 && s[1] !== 1'h1; k++)
        rd(`ADDR_TX_IRQ_STATUS);
      chk(s & 8'h02, 8'h02);
      chk(bits >> (8 - n), d & mk & ((8'h01 << n) - 8'h01));
      repeat (m == 2'h0 ? 136 : 72) @(posedge clk);
      rdc(`ADDR_TX_IRQ_STATUS, 8'h09);
      set_mode(1'h0, 1'h0, m);
      $display("test case %0d done", i);
    end
    complete_run;
  end
endmodule // dsss_transmit_serializer_tb_top

// File: verification/dsss_tx_checker.sv
// Purpose: Port checks of the transmit serializer
// Assumes: Chip period of two cycles or more
// Notes: Bound into every serializer instance
module dsss_tx_checker #(
  parameter [15:0] CHIP_CYCLES = 16'h0014
) (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire tx_enable,
  input wire rx_enable,
  input wire chip_out,
  input wire chip_strobe,
  input wire tx_active
);
  timeunit 1ns / 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire tx_mode = tx_enable & ~rx_enable;
  wire st_rd = ce & reg_rd & (reg_addr == 8'h0E);
  wire bad_rd = ce & reg_rd & (reg_addr < 8'h0E | reg_addr > 8'h18);
  ////////////////////////////////////////////////////////////////////////
  chk_st_off: assert property (st_rd && !tx_mode |=> reg_rdata == 8'h00)
    else $error("status set outside transmit");
  chk_st_upper: assert property (st_rd |=> reg_rdata[7:4] == 4'h0)
    else $error("status upper bits set");
  chk_unmapped_rd: assert property (bad_rd |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_act_mode: assert property (tx_active |-> $past(tx_mode))
    else $error("active outside transmit");
  chk_act_start: assert property ($rose(tx_mode) && ce |=> tx_active)
    else $error("active late");
  chk_first_chip: assert property ($rose(tx_active) |=> chip_strobe)
    else $error("first chip late");
  chk_strobe_pulse: assert property (chip_strobe |-> tx_active ##1 !chip_strobe)
    else $error("bad chip strobe");
  chk_chip_hold: assert property (tx_active && !chip_strobe |-> $stable(chip_out))
    else $error("chip moved off strobe");
  cover property (chip_strobe);
  cover property (st_rd ##1 reg_rdata[1]);
  cover property (st_rd ##1 reg_rdata[3]);
endmodule // dsss_tx_checker

bind dsss_transmit_serializer dsss_tx_checker #(.CHIP_CYCLES(CHIP_CYCLES))
  u_chk (.clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_enable(tx_enable),
  .rx_enable(rx_enable), .chip_out(chip_out), .chip_strobe(chip_strobe),
  .tx_active(tx_active));
